// File: src/sstp_pkg.sv
package sstp_pkg;

    // ==========================================================
    // strap codes and pin count
    localparam int          PIN_N       = 8;
    localparam int          CODE_W      = 3;
    localparam logic [2:0]  CODE_DEFAULT = 3'h0;
    localparam logic [2:0]  CODE_CLKDBG = 3'h2;

    // ==========================================================
    // output source selection per probe pin
    typedef enum logic [2:0] {
        SSTP_SRC_HIZ  = 3'h0,
        SSTP_SRC_F60  = 3'h1,
        SSTP_SRC_FVAR = 3'h2,
        SSTP_SRC_F30  = 3'h3,
        SSTP_SRC_F7P5 = 3'h5,
        SSTP_SRC_HIGH = 3'h6,
        SSTP_SRC_LOW  = 3'h7
    } sstp_src_t;

    // clock debug defaults, pin 0 first
    localparam sstp_src_t CLKDBG_SEL [PIN_N] = '{
        SSTP_SRC_F60, SSTP_SRC_F30, SSTP_SRC_FVAR, SSTP_SRC_HIGH,
        SSTP_SRC_LOW, SSTP_SRC_HIGH, SSTP_SRC_HIGH, SSTP_SRC_F7P5
    };

    // ==========================================================
    // timing: frequencies in kHz, half periods in cycles
    localparam int CLK_KHZ  = 125000;
    localparam int F60_KHZ  = 60000;
    localparam int F30_KHZ  = 30000;
    localparam int FVAR_KHZ = 10000;
    localparam int F7P5_KHZ = 7500;

    // half period rounds down, never below one cycle
    function automatic int half_cyc(input int f_khz);
        int h;
        h = CLK_KHZ / (2 * f_khz);
        return (h < 1) ? 1 : h;
    endfunction

    localparam int WAVE_N    = 4;
    localparam int WAVE_F60  = 0;
    localparam int WAVE_F30  = 1;
    localparam int WAVE_FVAR = 2;
    localparam int WAVE_F7P5 = 3;
    localparam int HALF_CYC [WAVE_N] = '{
        half_cyc(F60_KHZ), half_cyc(F30_KHZ),
        half_cyc(FVAR_KHZ), half_cyc(F7P5_KHZ)
    };
    localparam int DIV_W = 4;

endpackage

// File: src/sstp_clk_if.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// debug waveforms from the divider to the pin logic
interface sstp_clk_if;
    logic [3:0] wave;
    modport gen (output wave);
    modport sink (input  wave);
endinterface

`default_nettype wire

// File: src/sstp_clkgen.sv
`timescale 1ns/100ps
`default_nettype none

module sstp_clkgen
    import sstp_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    sstp_clk_if.gen     ck
);

    logic [WAVE_N-1:0] wave_r;

    assign ck.wave = wave_r;

    // ==========================================================
    // one divider per rate: enable pulse, then toggle
    for (genvar g = 0; g < WAVE_N; g++) begin : g_div
        localparam logic [DIV_W-1:0] LAST = DIV_W'(HALF_CYC[g] - 1);
        logic [DIV_W-1:0] cnt_r;
        logic             en;

        assign en = (cnt_r == LAST);

        // counter restarts on reset so all waves start aligned
        always_ff @(posedge clk) begin
            if (rst || en) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end

        // rates are the nearest reachable from 125 MHz
        always_ff @(posedge clk) begin
            if (rst) begin
                wave_r[g] <= 1'b0;
            end else if (en) begin
                wave_r[g] <= ~wave_r[g];
            end
        end
    end

    // ==========================================================
    property p_fast_toggle;
        @(posedge clk) (!rst ##1 !rst) |-> $changed(wave_r[WAVE_F60]);
    endproperty
    a_fast_toggle: assert property (p_fast_toggle)
        else $error("fast debug clock did not toggle");

endmodule

`default_nettype wire

// File: src/sstp_top.sv
`timescale 1ns/100ps
`default_nettype none

module sstp_top
    import sstp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  debug_probe_pins,
    output logic      [7:0]  debug_probe_level,
    output logic      [7:0]  debug_probe_pins_oe_n,
    output logic             debug_probe_pulldown_en,
    input  wire logic        sel_we,
    input  wire logic [2:0]  sel_pin,
    input  wire logic [2:0]  sel_src,
    output logic      [2:0]  test_mode,
    output logic             test_mode_valid
);

    logic [7:0]    pin_s1_r;
    logic [7:0]    pin_s2_r;
    logic          rel_pend_r;
    logic          capture;
    logic [2:0]    mode_r;
    logic          valid_r;
    sstp_src_t     sel_r [PIN_N];
    logic [7:0]    out_r;
    logic [7:0]    oe_n_r;
    logic          pd_r;
    sstp_clk_if    ck ();

    // waveform source for clock debug pins
    sstp_clkgen u_clkgen (
        .clk (clk),
        .rst (rst),
        .ck  (ck.gen)
    );

    // level and enable for one pin from its source
    function automatic logic [1:0] pin_drive(input sstp_src_t s,
                                             input logic [3:0] w);
        logic [1:0] r;
        r = 2'b10;
        unique case (s)
            SSTP_SRC_F60:  r = {1'b0, w[WAVE_F60]};
            SSTP_SRC_F30:  r = {1'b0, w[WAVE_F30]};
            SSTP_SRC_FVAR: r = {1'b0, w[WAVE_FVAR]};
            SSTP_SRC_F7P5: r = {1'b0, w[WAVE_F7P5]};
            SSTP_SRC_HIGH: r = 2'b01;
            SSTP_SRC_LOW:  r = 2'b00;
            default:       r = 2'b10;
        endcase
        return r;
    endfunction

    // ==========================================================
    // pin synchroniser, no reset so strap levels flow through
    always_ff @(posedge clk) begin
        pin_s1_r <= debug_probe_pins;
        pin_s2_r <= pin_s1_r;
    end

    // ==========================================================
    // strap capture: first cycle after reset releases
    assign capture = rel_pend_r && !rst;

    always_ff @(posedge clk) begin
        if (rst) begin
            rel_pend_r <= 1'b1;
        end else begin
            rel_pend_r <= 1'b0;
        end
    end

    // captured code only changes on reset or a release, never from pins later
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r  <= CODE_DEFAULT;
            valid_r <= 1'b0;
        end else if (capture) begin
            mode_r  <= pin_s2_r[CODE_W-1:0];
            valid_r <= 1'b1;
        end
    end

    // ==========================================================
    // per-pin selection: strap defaults, then software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < PIN_N; i++) begin
                sel_r[i] <= SSTP_SRC_HIZ;
            end
        end else if (capture) begin
            for (int i = 0; i < PIN_N; i++) begin
                if (pin_s2_r[CODE_W-1:0] == CODE_CLKDBG) begin
                    sel_r[i] <= CLKDBG_SEL[i];
                end else begin
                    sel_r[i] <= SSTP_SRC_HIZ;
                end
            end
        end else if (sel_we && valid_r) begin
            // write in the capture cycle is dropped: strap wins
            sel_r[sel_pin] <= sstp_src_t'(sel_src);
        end
    end

    // ==========================================================
    // output flops; enables held off through reset
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r  <= 8'h00;
            oe_n_r <= 8'hFF;
        end else begin
            for (int i = 0; i < PIN_N; i++) begin
                {oe_n_r[i], out_r[i]} <= pin_drive(sel_r[i], ck.wave);
            end
        end
    end

    // pulldown is kept on always so open pins strap to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            pd_r <= 1'b1;
        end else begin
            pd_r <= 1'b1;
        end
    end

    assign debug_probe_level       = out_r;
    assign debug_probe_pins_oe_n   = oe_n_r;
    assign debug_probe_pulldown_en = pd_r;
    assign test_mode               = mode_r;
    assign test_mode_valid         = valid_r;

    // ==========================================================
    // checks
    property p_rst_inputs;
        @(posedge clk) rst |=> (oe_n_r == 8'hFF);
    endproperty
    a_rst_inputs: assert property (p_rst_inputs)
        else $error("probe pins driven during reset");

    property p_outputs_on;
        @(posedge clk) disable iff (rst)
        ($fell(rst) ##1 (mode_r == CODE_CLKDBG)) |=> (oe_n_r == 8'h00);
    endproperty
    a_outputs_on: assert property (p_outputs_on)
        else $error("probe pins not driven after release");

    property p_capture;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> ##1 (mode_r == $past(pin_s2_r[2:0]) && valid_r);
    endproperty
    a_capture: assert property (p_capture)
        else $error("strap code not captured at release");

    property p_hold;
        @(posedge clk) disable iff (rst)
        (valid_r && !capture) |=> $stable(mode_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("test mode changed without reset");

    property p_pulldown;
        @(posedge clk) disable iff (rst) 1'b1 |=> pd_r;
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pulldown not enabled");

    property p_default_hiz;
        @(posedge clk) disable iff (rst)
        ($rose(valid_r) && mode_r == CODE_DEFAULT) |=> (oe_n_r == 8'hFF);
    endproperty
    a_default_hiz: assert property (p_default_hiz)
        else $error("default code drove a probe pin");

    property p_clkdbg;
        @(posedge clk) disable iff (rst)
        ($rose(valid_r) && mode_r == CODE_CLKDBG) |=>
            (oe_n_r == 8'h00 && out_r[6:3] == 4'hD);
    endproperty
    a_clkdbg: assert property (p_clkdbg)
        else $error("clock debug fixed levels wrong");

    property p_sw_sel;
        @(posedge clk) disable iff (rst)
        (sel_we && valid_r && !capture && sel_src == 3'h6) |=>
            ##1 (oe_n_r[$past(sel_pin, 2)] == 1'b0
                 && out_r[$past(sel_pin, 2)] == 1'b1);
    endproperty
    a_sw_sel: assert property (p_sw_sel)
        else $error("software selection not applied");

    property p_other_hiz;
        @(posedge clk) disable iff (rst)
        ($rose(valid_r) && mode_r != CODE_DEFAULT
         && mode_r != CODE_CLKDBG) |=> (oe_n_r == 8'hFF);
    endproperty
    a_other_hiz: assert property (p_other_hiz)
        else $error("undocumented code drove a probe pin");

endmodule

`default_nettype wire

// File: tb/sstp_board.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// board side: strap resistors and the resolved pin levels
module sstp_board (
    input  wire logic [2:0] strap_up,
    input  wire logic [7:0] drv,
    input  wire logic [7:0] drv_oe_n,
    input  wire logic       pull_dn,
    output logic      [7:0] pins
);
    // only the low three pins get a jumper, upper five float on pulldown
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!drv_oe_n[i]) begin
                pins[i] = drv[i];
            end else if (i < 3 && strap_up[i]) begin
                pins[i] = 1'b1;
            end else if (pull_dn) begin
                pins[i] = 1'b0;
            end else begin
                pins[i] = ~drv[i]; // floating: never trust last value
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/test_strap_sampled_test_point_port.sv
`timescale 1ns/100ps
`default_nettype none

module test_strap_sampled_test_point_port
    import sstp_pkg::*;
;
    typedef struct {
        int          kind;
        logic [31:0] mask;
        logic [31:0] exp;
    } sstp_note_t;

    logic        clk, rst, sel_we, pd, valid, smp;
    logic [2:0]  sel_pin, sel_src, mode, strap_up;
    logic [7:0]  o, oe_n, pins, eoe, eo, em;
    logic [31:0] seed, tg, seen;
    int          n_mismatch, n_checks, c;
    sstp_note_t  q[$];
    sstp_note_t  nt;

    // ==========================================================
    // design and board
    sstp_top uut (.clk(clk), .rst(rst), .debug_probe_pins(pins),
        .debug_probe_level(o), .debug_probe_pins_oe_n(oe_n),
        .debug_probe_pulldown_en(pd), .sel_we(sel_we),
        .sel_pin(sel_pin), .sel_src(sel_src), .test_mode(mode),
        .test_mode_valid(valid));
    sstp_board board (.strap_up(strap_up), .drv(o), .drv_oe_n(oe_n),
        .pull_dn(pd), .pins(pins));

    always #4 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string nm, input logic [31:0] sn, ex);
        n_checks++;
        if (sn !== ex) begin
            n_mismatch++;
            $display("Error %s exp %h seen %h", nm, ex, sn);
        end
    endtask

    // note the expectation, flag the monitor for this cycle
    task automatic sample(input int k, input logic [31:0] m, ex);
        q.push_back('{k, m, ex});
        smp = 1'b1;
        tick();
        smp = 1'b0;
    endtask

    // ==========================================================
    // monitor: outputs are settled by the falling edge
    always @(negedge clk) begin
        if (smp && q.size() > 0) begin
            nt = q.pop_front();
            seen = nt.kind ? tg : {11'h0, pd, valid, mode, oe_n, o};
            check("outputs", seen & nt.mask, nt.exp & nt.mask);
        end
    end

    // writes during reset must be dropped, straps change after release
    task automatic do_reset(input logic [2:0] cd);
        logic [31:0] e, m;
        strap_up = cd;
        rst = 1'b1;
        sel_we = 1'b1;
        sel_pin = 3'h0;
        sel_src = 3'h6;
        repeat (12) tick();
        sample(0, 32'h001FFFFF, {11'h0, 5'h10, 8'hFF, 8'h00});
        rst = 1'b0;
        sel_we = 1'b0;
        repeat (2) tick();
        e = {11'h0, 2'h3, cd, (cd == CODE_CLKDBG) ? 8'h00 : 8'hFF, 8'h68};
        m = (cd == CODE_CLKDBG) ? 32'h001FFF78 : 32'h001FFF00;
        sample(0, m, e);
        strap_up = ~cd;
        repeat (3) tick();
        sample(0, m, e);
    endtask

    // toggles over 48 cycles; 48 is a multiple of every half period
    task automatic meas();
        int          k;
        logic [7:0]  p;
        int          idx [4] = '{0, 1, 2, 7};
        tg = 32'h0;
        p = o;
        repeat (48) begin
            tick();
            for (k = 0; k < 4; k++) begin
                tg[8*k +: 8] += 8'(o[idx[k]] !== p[idx[k]]);
            end
            p = o;
        end
        sample(1, 32'hFFFFFFFF, {8'(48 / HALF_CYC[WAVE_F7P5]),
            8'(48 / HALF_CYC[WAVE_FVAR]), 8'(48 / HALF_CYC[WAVE_F30]),
            8'(48 / HALF_CYC[WAVE_F60])});
    endtask

    // back-to-back writes, pin 7 written twice so the last must win
    task automatic sel_round();
        int         i;
        logic [2:0] s;
        sel_we = 1'b1;
        sel_pin = 3'h7;
        sel_src = 3'h6;
        tick();
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            s = seed[2:0];
            sel_pin = i[2:0];
            sel_src = s;
            eoe[i] = (s == SSTP_SRC_HIZ || s == 3'h4);
            eo[i] = (s == SSTP_SRC_HIGH);
            em[i] = (s == SSTP_SRC_HIGH || s == SSTP_SRC_LOW);
            tick();
        end
        sel_we = 1'b0;
        repeat (2) tick();
        sample(0, {11'h0, 5'h1F, 8'hFF, em},
            {11'h0, 2'h3, CODE_DEFAULT, eoe, eo});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence: every strap code, then software selection
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sel_we = 1'b0;
        sel_pin = 3'h0;
        sel_src = 3'h0;
        strap_up = 3'h0;
        smp = 1'b0;
        tg = 32'h0;
        seed = 32'h8B7BCB38;
        n_mismatch = 0;
        n_checks = 0;
        for (c = 0; c < 8; c++) begin
            do_reset(c[2:0]);
            if (c == 2) meas();
        end
        do_reset(CODE_DEFAULT);
        repeat (4) sel_round();
        do_reset(CODE_CLKDBG); // reset drops software selections
        tick();
        conclude();
    end

    // watchdog, far beyond the roughly 300 cycles of the sequence
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule

`default_nettype wire
